// *** hdl/xcvr_ctrl_pkg.sv ***
// shared types, constants and decode helpers for the transceiver static control block
package xcvr_ctrl_pkg;

    // ------------------------------------------------------------
    // three-level selects
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_LOW = 2'b00,
        LVL_MID = 2'b01,
        LVL_HIGH = 2'b10
    } level_type;

    typedef enum logic [1:0] {
        RATE_195_400 = 2'b00,
        RATE_400_800 = 2'b01,
        RATE_800_1500 = 2'b10
    } rate_range_type;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic [1:0] control;
        logic parity;
    } tx_word_type;

    typedef struct packed {
        logic [7:0] data;
        logic [2:0] status;
    } rx_word_type;

    typedef struct packed {
        logic seen;
        logic [3:0] offset;
        logic disparity_ok;
    } frame_hit_type;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int CHAR_BITS = 10;
    localparam int WINDOW_BITS = 50;
    localparam logic [2:0] WINDOW_CHARS = 3'((WINDOW_BITS - CHAR_BITS) / CHAR_BITS);
    localparam logic [2:0] CONSEC_CHARS = 3'h4;
    localparam logic [3:0] OFFSET_RESET = 4'h0;
    localparam int SETTLE_LIMIT = 16;
    localparam logic [3:0] SETTLE_CYCLES = 4'h8;
    localparam logic [3:0] EBUF_NOMINAL = 4'h8;
    localparam logic [3:0] EBUF_READ_RESET = 4'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // 2'b00 low, 2'b01 middle, anything else high
    function automatic level_type decode_level(input logic [1:0] code);
        case (code)
            2'b00: decode_level = LVL_LOW;
            2'b01: decode_level = LVL_MID;
            default: decode_level = LVL_HIGH;
        endcase
    endfunction

    // bit that makes the total count of ones odd
    function automatic logic odd_fill(input logic [10:0] bits);
        odd_fill = ~(^bits);
    endfunction

endpackage

// *** hdl/parity_unit.sv ***
// odd parity check on the transmit word and odd parity generation for the receive word
`timescale 1ns/10ps
module parity_unit
    import xcvr_ctrl_pkg::*;
(
    input wire xcvr_ctrl_pkg::level_type parity_mode,
    input wire logic encoder_on,
    input wire logic decoder_on,
    input wire xcvr_ctrl_pkg::tx_word_type tx_word,
    input wire xcvr_ctrl_pkg::rx_word_type rx_word,
    output logic tx_parity_bad,
    output logic rx_parity,
    output logic rx_parity_drive
);

    logic [10:0] tx_cover;
    logic [10:0] rx_cover;

    always_comb
    begin
        tx_cover = {3'h0, tx_word.data};
        rx_cover = {3'h0, rx_word.data};
        case (parity_mode)
            LVL_MID:
            begin
                if (!encoder_on)
                begin
                    tx_cover = {1'b0, tx_word.control, tx_word.data}; // see RULE6
                end
                if (!decoder_on)
                begin
                    rx_cover = {1'b0, rx_word.status[1:0], rx_word.data}; // see RULE6
                end
            end
            LVL_HIGH:
            begin
                tx_cover = {1'b0, tx_word.control, tx_word.data}; // see RULE7
                rx_cover = {rx_word.status, rx_word.data}; // see RULE7
            end
            default:
            begin
                tx_cover = {3'h0, tx_word.data};
                rx_cover = {3'h0, rx_word.data};
            end
        endcase
        // data plus its parity bit must hold an odd count of ones
        tx_parity_bad = (parity_mode != LVL_LOW)
            && (odd_fill(tx_cover) != tx_word.parity); // see RULE5
        rx_parity = (parity_mode != LVL_LOW) && odd_fill(rx_cover); // see RULE5
        rx_parity_drive = (parity_mode != LVL_LOW); // see RULE4
    end

endmodule

// *** hdl/char_framer.sv ***
// character framer: low-latency, pair-in-window and four-in-a-row modes
`timescale 1ns/10ps
module char_framer
    import xcvr_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic clear,
    input wire xcvr_ctrl_pkg::level_type mode,
    input wire logic char_valid,
    input wire xcvr_ctrl_pkg::frame_hit_type hit,
    output logic [3:0] offset,
    output logic clk_stretch,
    output logic reframe
);

    logic [3:0] cand_offset;
    logic cand_valid;
    logic [2:0] cand_age;
    logic [2:0] run_cnt;
    logic [3:0] next_offset;
    logic [3:0] next_cand_offset;
    logic next_cand_valid;
    logic [2:0] next_cand_age;
    logic [2:0] next_run_cnt;
    logic next_clk_stretch;
    logic next_reframe;

    always_comb
    begin
        next_offset = offset;
        next_cand_offset = cand_offset;
        next_cand_valid = cand_valid;
        next_cand_age = cand_age;
        next_run_cnt = run_cnt;
        next_clk_stretch = 1'b0;
        next_reframe = 1'b0;
        if (char_valid)
        begin
            case (mode)
                LVL_LOW:
                begin
                    if (hit.seen)
                    begin
                        next_reframe = 1'b1; // see RULE14
                        next_offset = hit.offset;
                        next_clk_stretch = (hit.offset != offset); // see RULE14
                    end
                end
                LVL_MID:
                begin
                    if (hit.seen && cand_valid && hit.offset == cand_offset
                        && cand_age < WINDOW_CHARS)
                    begin
                        next_reframe = 1'b1; // see RULE1
                        next_offset = hit.offset; // see RULE2
                        next_cand_valid = 1'b0;
                    end
                    else if (hit.seen)
                    begin
                        next_cand_offset = hit.offset;
                        next_cand_valid = 1'b1;
                        next_cand_age = 3'h0;
                    end
                    else if (cand_age != 3'h7)
                    begin
                        next_cand_age = cand_age + 3'h1;
                    end
                end
                LVL_HIGH:
                begin
                    if (hit.seen && hit.disparity_ok
                        && (run_cnt == 3'h0 || hit.offset == cand_offset))
                    begin
                        next_cand_offset = hit.offset;
                        if (run_cnt + 3'h1 == CONSEC_CHARS)
                        begin
                            next_reframe = 1'b1; // see RULE3
                            next_offset = hit.offset; // see RULE2
                            next_run_cnt = 3'h0;
                        end
                        else
                        begin
                            next_run_cnt = run_cnt + 3'h1;
                        end
                    end
                    else if (hit.seen && hit.disparity_ok)
                    begin
                        next_cand_offset = hit.offset;
                        next_run_cnt = 3'h1;
                    end
                    else
                    begin
                        next_run_cnt = 3'h0; // see RULE3
                    end
                end
                default:
                begin
                    next_run_cnt = 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst || clear)
        begin
            offset <= OFFSET_RESET;
            cand_offset <= OFFSET_RESET;
            cand_valid <= 1'b0;
            cand_age <= 3'h0;
            run_cnt <= 3'h0;
            clk_stretch <= 1'b0;
            reframe <= 1'b0;
        end
        else if (ce)
        begin
            offset <= next_offset;
            cand_offset <= next_cand_offset;
            cand_valid <= next_cand_valid;
            cand_age <= next_cand_age;
            run_cnt <= next_run_cnt;
            clk_stretch <= next_clk_stretch;
            reframe <= next_reframe;
        end
    end

    chk_multi_no_stretch: assert property (@(posedge ref_clk) disable iff (srst) // see RULE2
        clk_stretch |-> $past(mode) == LVL_LOW)
        else $error("stretch outside low-latency mode");
    chk_pair_window: assert property (@(posedge ref_clk) disable iff (srst) // see RULE1
        ($past(mode) == LVL_MID && reframe) |-> $past(cand_valid)
            && $past(cand_age) < WINDOW_CHARS)
        else $error("pair reframe outside window");
    chk_four_run: assert property (@(posedge ref_clk) disable iff (srst) // see RULE3
        ($past(mode) == LVL_HIGH && reframe) |-> $past(run_cnt) == CONSEC_CHARS - 3'h1)
        else $error("reframe without four-character run");

endmodule

// *** hdl/xcvr_static_ctrl.sv ***
// top of the transceiver static control block: selects, reset, latches, parity and framing
//
// How it works
// RULE1 - in middle framing mode, two framing characters at one alignment within 50 bits reframe.
// RULE2 - both multi-byte framing modes keep the character clock phase whatever the offset.
// RULE3 - in high framing mode, four consecutive allowed-disparity framing characters at one alignment reframe.
// RULE4 - with parity control low nothing is checked and the receive parity pin is undriven.
// RULE5 - parity middle with coding on: odd parity over tx byte plus parity bit and over rx byte.
// RULE6 - parity middle with coding bypassed: tx control bits and rx status [1:0] join the parity.
// RULE7 - parity high: tx byte and control bits are checked, rx byte plus status [2:0] covered.
// RULE8 - the rate select picks the 195-400, 400-800 or 800-1500 MBaud range of both PLLs.
// RULE9 - the controller must not pick the half-rate reference with the rate select low.
// RULE10 - reset sampled low clears all state machines and counters and sets nominal pointer offset.
// RULE11 - status and data outputs settle in fewer than 16 clocks after reset release.
// RULE12 - reset clears the self-test, output-enable and receive-channel latches.
// RULE13 - the controller should reset after power-up when the buffers are used.
// RULE14 - low framing mode reframes on every framing character, stretching the character clock when the offset changes.
// RULE15 - with the decoder select low, raw 10-bit characters pass to the receive register.
// RULE16 - each three-level select is held stable and decodes to low, middle or high.
`timescale 1ns/10ps
module xcvr_static_ctrl
    import xcvr_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic device_init_n,
    input wire logic [1:0] framer_mode_select,
    input wire logic [1:0] parity_control_select,
    input wire logic [1:0] serial_rate_select,
    input wire logic [1:0] tx_encode_select,
    input wire logic [1:0] decoder_select,
    input wire logic [1:0] tx_ref_rate_select,
    input wire xcvr_ctrl_pkg::tx_word_type tx_parallel_byte,
    input wire logic rx_char_valid,
    input wire logic [9:0] rx_raw_char,
    input wire xcvr_ctrl_pkg::rx_word_type rx_decoded,
    input wire xcvr_ctrl_pkg::frame_hit_type frame_hit,
    input wire logic selftest_latch_enable,
    input wire logic output_enable_latch,
    input wire logic rx_channel_latch_enable,
    input wire logic selftest_request,
    input wire logic output_enable_request,
    input wire logic rx_channel_request,
    output xcvr_ctrl_pkg::rx_word_type rx_parallel_byte,
    output logic rx_parity_out,
    output logic rx_parity_oe,
    output logic tx_parity_error,
    output logic [3:0] char_offset,
    output logic char_clk_stretch,
    output logic reframe_pulse,
    output xcvr_ctrl_pkg::rate_range_type rate_range,
    output logic rate_config_invalid,
    output logic selftest_active,
    output logic outputs_enabled,
    output logic rx_channel_enabled,
    output logic [3:0] ebuf_wr_ptr,
    output logic [3:0] ebuf_rd_ptr,
    output logic status_ready
);

    // ------------------------------------------------------------
    // select decode and reset
    // ------------------------------------------------------------
    level_type framer_mode;
    level_type parity_mode;
    level_type rate_level;
    level_type encode_level;
    level_type decode_mode;
    level_type ref_rate_level;
    logic held_reset;
    logic encoder_on;
    logic decoder_on;

    always_comb
    begin
        framer_mode = decode_level(framer_mode_select); // see RULE16
        parity_mode = decode_level(parity_control_select); // see RULE16
        rate_level = decode_level(serial_rate_select); // see RULE16
        encode_level = decode_level(tx_encode_select); // see RULE16
        decode_mode = decode_level(decoder_select); // see RULE16
        ref_rate_level = decode_level(tx_ref_rate_select); // see RULE16
        encoder_on = (encode_level != LVL_LOW);
        decoder_on = (decode_mode != LVL_LOW);
        // pin is sampled on the clock edge like every other input
        held_reset = srst || !device_init_n; // see RULE10
    end

    // ------------------------------------------------------------
    // parity and framing
    // ------------------------------------------------------------
    rx_word_type rx_word;
    logic tx_bad;
    logic rx_par;
    logic rx_par_drive;

    always_comb
    begin
        if (decoder_on)
        begin
            rx_word = rx_decoded;
        end
        else
        begin
            // raw character: low eight bits as data, top two in status[1:0]
            rx_word = '{data: rx_raw_char[7:0], status: {1'b0, rx_raw_char[9:8]}}; // see RULE15
        end
    end

    parity_unit parity
    (
        .parity_mode(parity_mode),
        .encoder_on(encoder_on),
        .decoder_on(decoder_on),
        .tx_word(tx_parallel_byte),
        .rx_word(rx_word),
        .tx_parity_bad(tx_bad),
        .rx_parity(rx_par),
        .rx_parity_drive(rx_par_drive)
    );

    char_framer framer
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .clear(held_reset), // see RULE10
        .mode(framer_mode),
        .char_valid(rx_char_valid),
        .hit(frame_hit),
        .offset(char_offset),
        .clk_stretch(char_clk_stretch),
        .reframe(reframe_pulse)
    );

    // ------------------------------------------------------------
    // registered state
    // ------------------------------------------------------------
    rx_word_type next_rx_parallel_byte;
    logic next_rx_parity_out;
    logic next_rx_parity_oe;
    logic next_tx_parity_error;
    rate_range_type next_rate_range;
    logic next_rate_config_invalid;
    logic next_selftest_active;
    logic next_outputs_enabled;
    logic next_rx_channel_enabled;
    logic [3:0] next_ebuf_wr_ptr;
    logic [3:0] next_ebuf_rd_ptr;
    logic [3:0] settle_cnt;
    logic [3:0] next_settle_cnt;
    logic next_status_ready;

    always_comb
    begin
        next_rx_parallel_byte = rx_parallel_byte;
        if (rx_char_valid)
        begin
            next_rx_parallel_byte = rx_word; // see RULE15
        end
        next_rx_parity_out = rx_par_drive ? rx_par : 1'b0; // see RULE4
        next_rx_parity_oe = rx_par_drive; // see RULE4
        next_tx_parity_error = tx_bad; // see RULE5
        case (rate_level)
            LVL_LOW: next_rate_range = RATE_195_400; // see RULE8
            LVL_MID: next_rate_range = RATE_400_800; // see RULE8
            default: next_rate_range = RATE_800_1500; // see RULE8
        endcase
        // flag the combination the controller must avoid
        next_rate_config_invalid = (rate_level == LVL_LOW)
            && (ref_rate_level == LVL_HIGH); // see RULE9
        next_selftest_active = selftest_latch_enable ? selftest_request : selftest_active;
        next_outputs_enabled = output_enable_latch ? output_enable_request : outputs_enabled;
        next_rx_channel_enabled = rx_channel_latch_enable ? rx_channel_request
            : rx_channel_enabled;
        // pointer pair free-runs keeping the nominal separation
        next_ebuf_wr_ptr = ebuf_wr_ptr + 4'h1;
        next_ebuf_rd_ptr = ebuf_rd_ptr + 4'h1;
        next_settle_cnt = settle_cnt;
        next_status_ready = status_ready;
        if (settle_cnt == SETTLE_CYCLES - 4'h1)
        begin
            next_status_ready = 1'b1; // see RULE11
        end
        else
        begin
            next_settle_cnt = settle_cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (held_reset)
        begin
            rx_parallel_byte <= '{data: BYTE_RESET, status: STATUS_RESET}; // see RULE11
            rx_parity_out <= 1'b0;
            rx_parity_oe <= 1'b0;
            tx_parity_error <= 1'b0;
            rate_range <= RATE_195_400;
            rate_config_invalid <= 1'b0;
            selftest_active <= 1'b0; // see RULE12
            outputs_enabled <= 1'b0; // see RULE12
            rx_channel_enabled <= 1'b0; // see RULE12
            ebuf_wr_ptr <= EBUF_NOMINAL; // see RULE10
            ebuf_rd_ptr <= EBUF_READ_RESET; // see RULE10
            settle_cnt <= 4'h0; // see RULE10
            status_ready <= 1'b0;
        end
        else if (ce)
        begin
            rx_parallel_byte <= next_rx_parallel_byte;
            rx_parity_out <= next_rx_parity_out;
            rx_parity_oe <= next_rx_parity_oe;
            tx_parity_error <= next_tx_parity_error;
            rate_range <= next_rate_range;
            rate_config_invalid <= next_rate_config_invalid;
            selftest_active <= next_selftest_active;
            outputs_enabled <= next_outputs_enabled;
            rx_channel_enabled <= next_rx_channel_enabled;
            ebuf_wr_ptr <= next_ebuf_wr_ptr;
            ebuf_rd_ptr <= next_ebuf_rd_ptr;
            settle_cnt <= next_settle_cnt;
            status_ready <= next_status_ready;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking

    sequence reset_release;
        held_reset ##1 !held_reset;
    endsequence

    sequence running_cycles;
        (ce && !held_reset) [*8];
    endsequence

    chk_settle_ready: assert property (reset_release ##0 running_cycles |=> status_ready) // see RULE11
        else $error("status not ready in time");
    chk_latch_clear: assert property (held_reset |=> // see RULE12
        !selftest_active && !outputs_enabled && !rx_channel_enabled)
        else $error("latches not cleared by reset");
    chk_ptr_nominal: assert property (held_reset |=> // see RULE10
        ebuf_wr_ptr - ebuf_rd_ptr == EBUF_NOMINAL && !status_ready)
        else $error("pointers not nominal after reset");
    chk_parity_off: assert property (disable iff (srst) // see RULE4
        (ce && !held_reset && parity_mode == LVL_LOW) |=> !rx_parity_oe && !tx_parity_error)
        else $error("parity active while off");
    chk_rx_parity_gen: assert property (disable iff (srst) // see RULE5
        (ce && !held_reset && parity_mode == LVL_MID && decoder_on)
        |=> rx_parity_out == ~(^$past(rx_word.data)))
        else $error("receive parity wrong in middle mode");
    chk_rx_parity_high: assert property (disable iff (srst) // see RULE7
        (ce && !held_reset && parity_mode == LVL_HIGH)
        |=> rx_parity_out == ~(^{$past(rx_word.status), $past(rx_word.data)}))
        else $error("receive parity wrong in high mode");
    chk_rate_decode: assert property (disable iff (srst) // see RULE8
        (ce && !held_reset && rate_level == LVL_MID) |=> rate_range == RATE_400_800)
        else $error("rate range wrong");
    chk_rate_invalid: assert property (disable iff (srst) // see RULE9
        (ce && !held_reset && rate_level == LVL_LOW && ref_rate_level == LVL_HIGH)
        |=> rate_config_invalid)
        else $error("invalid rate not flagged");

endmodule

// *** dv/sys_side_model.sv ***
// system-side model that drives the transmit word with odd parity over the covered bits
`timescale 1ns/10ps
module sys_side_model
    import xcvr_ctrl_pkg::*;
(
    input wire logic [7:0] data,
    input wire logic [1:0] control,
    input wire logic [1:0] parity_sel,
    input wire logic [1:0] encode_sel,
    input wire logic make_bad,
    output xcvr_ctrl_pkg::tx_word_type word
);
    logic cover_ctl;
    // control bits join in high mode, or in middle mode with the encoder off
    assign cover_ctl = parity_sel[1] | (parity_sel == 2'h1 && encode_sel == 2'h0);
    // make_bad flips the parity bit
    assign word = '{data, control, ~^{data, control & {2{cover_ctl}}} ^ make_bad};
endmodule

// *** dv/transceiver_static_control_tb_top.sv ***
// self-checking bench for the transceiver static control block
`timescale 1ns/10ps
module transceiver_static_control_tb_top;
    import xcvr_ctrl_pkg::*;
    typedef struct packed {
        logic [1:0] par, enc, dec, ssel, tref;
        logic [7:0] txd;
        logic [1:0] txc;
        logic bad;
        logic [7:0] rxd;
        logic [2:0] rxs;
        logic err, rpar, oe;
        logic [1:0] rate;
        logic inv;
    } row_type;
    // no row has rate low with half-rate reference
    row_type rows [8] = '{
        '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 8'h5a, 2'h1, 1'h1, 8'h01, 3'h7, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0},
        '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 8'h5a, 2'h1, 1'h0, 8'h01, 3'h1, 1'h0, 1'h0, 1'h1, 2'h1, 1'h0},
        '{2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 8'h5a, 2'h1, 1'h1, 8'h03, 3'h0, 1'h1, 1'h1, 1'h1, 2'h2, 1'h0},
        '{2'h1, 2'h0, 2'h0, 2'h3, 2'h0, 8'h0f, 2'h1, 1'h0, 8'h0f, 3'h1, 1'h0, 1'h0, 1'h1, 2'h2, 1'h0},
        '{2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 8'h3c, 2'h2, 1'h1, 8'h00, 3'h2, 1'h1, 1'h0, 1'h1, 2'h0, 1'h0},
        '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 8'h01, 2'h2, 1'h0, 8'h01, 3'h4, 1'h0, 1'h1, 1'h1, 2'h0, 1'h0},
        '{2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 8'h77, 2'h3, 1'h1, 8'h00, 3'h4, 1'h1, 1'h0, 1'h1, 2'h0, 1'h0},
        '{2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 8'h00, 2'h3, 1'h0, 8'h07, 3'h1, 1'h0, 1'h0, 1'h1, 2'h0, 1'h0}};
    logic ref_clk = 1'h0, srst = 1'h1, ce = 1'h1, device_init_n = 1'h1, rx_char_valid = 1'h0;
    logic [1:0] fsel = 2'h0, psel = 2'h0, ssel = 2'h0, esel = 2'h1, dsel = 2'h1, tsel = 2'h0;
    logic [7:0] pdata = 8'h00;
    logic [1:0] pctl = 2'h0;
    logic pbad = 1'h0, lat_en = 1'h0, lat_req = 1'h0;
    logic [9:0] rx_raw_char = 10'h000;
    rx_word_type rx_decoded = '0, rx_parallel_byte;
    frame_hit_type frame_hit = '0;
    tx_word_type tx_word;
    rate_range_type rate_range;
    logic rx_parity_out, rx_parity_oe, tx_parity_error, char_clk_stretch, reframe_pulse;
    logic rate_config_invalid, selftest_active, outputs_enabled, rx_channel_enabled, status_ready;
    logic [3:0] char_offset, ebuf_wr_ptr, ebuf_rd_ptr;
    int fail_count = 0, num_checks = 0, rf_count = 0, st_count = 0, rf0, st0, n;
    // ------------------------------------------------------------
    // clock, partner and design
    // ------------------------------------------------------------
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) rf_count += (reframe_pulse === 1'h1);
    always @(posedge ref_clk) st_count += (char_clk_stretch === 1'h1);
    sys_side_model partner_u (.data(pdata), .control(pctl), .parity_sel(psel), .encode_sel(esel),
        .make_bad(pbad), .word(tx_word));
    xcvr_static_ctrl dut_u (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .device_init_n(device_init_n), .framer_mode_select(fsel), .parity_control_select(psel),
        .serial_rate_select(ssel), .tx_encode_select(esel), .decoder_select(dsel),
        .tx_ref_rate_select(tsel), .tx_parallel_byte(tx_word), .rx_char_valid(rx_char_valid),
        .rx_raw_char(rx_raw_char), .rx_decoded(rx_decoded), .frame_hit(frame_hit),
        .selftest_latch_enable(lat_en), .output_enable_latch(lat_en),
        .rx_channel_latch_enable(lat_en), .selftest_request(lat_req),
        .output_enable_request(lat_req), .rx_channel_request(lat_req),
        .rx_parallel_byte(rx_parallel_byte), .rx_parity_out(rx_parity_out),
        .rx_parity_oe(rx_parity_oe), .tx_parity_error(tx_parity_error),
        .char_offset(char_offset), .char_clk_stretch(char_clk_stretch),
        .reframe_pulse(reframe_pulse), .rate_range(rate_range),
        .rate_config_invalid(rate_config_invalid), .selftest_active(selftest_active),
        .outputs_enabled(outputs_enabled), .rx_channel_enabled(rx_channel_enabled),
        .ebuf_wr_ptr(ebuf_wr_ptr), .ebuf_rd_ptr(ebuf_rd_ptr), .status_ready(status_ready));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask
    task automatic test_done();
        if (fail_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chars(input int k, input logic s, input logic [3:0] off, input logic dok);
        repeat (k)
        begin
            @(posedge ref_clk);
            rx_char_valid <= 1'h1;
            frame_hit <= '{s, off, dok};
        end
    endtask
    task automatic settle();
        @(posedge ref_clk);
        rx_char_valid <= 1'h0;
        frame_hit <= '{1'h1, 4'h9, 1'h1};
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    initial
    begin
        #(25 * 4000);
        fail_count++;
        test_done();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'h0;
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            {psel, esel, dsel, ssel, tsel} <= {rows[i].par, rows[i].enc, rows[i].dec,
                rows[i].ssel, rows[i].tref};
            {pdata, pctl, pbad, rx_char_valid} <= {rows[i].txd, rows[i].txc, rows[i].bad, 1'h1};
            rx_decoded <= '{rows[i].rxd, rows[i].rxs};
            rx_raw_char <= {rows[i].rxs[1:0], rows[i].rxd};
            @(posedge ref_clk);
            #1;
            check(tx_parity_error, rows[i].err);
            check({rx_parity_oe, rx_parity_out}, {rows[i].oe, rows[i].rpar});
            check(rx_parallel_byte, {rows[i].rxd, rows[i].rxs});
            check({rate_range, rate_config_invalid}, {rows[i].rate, rows[i].inv});
        end
        st0 = st_count;
        fsel <= 2'h2;
        chars(3, 1'h1, 4'h5, 1'h1);
        chars(1, 1'h1, 4'h5, 1'h0);
        chars(3, 1'h1, 4'h5, 1'h1);
        settle();
        check(16'(rf_count), 0);
        chars(4, 1'h1, 4'h5, 1'h1);
        settle();
        check({rf_count[3:0], char_offset}, 8'h15);
        fsel <= 2'h1;
        chars(1, 1'h1, 4'h7, 1'h1);
        chars(4, 1'h0, 4'h7, 1'h1);
        chars(1, 1'h1, 4'h7, 1'h1);
        settle();
        check({rf_count[3:0], char_offset}, 8'h15);
        chars(3, 1'h0, 4'h7, 1'h1);
        chars(1, 1'h1, 4'h7, 1'h1);
        settle();
        check({rf_count[3:0], char_offset}, 8'h27);
        check(st_count - st0, 0);
        rf0 = rf_count;
        fsel <= 2'h0;
        chars(2, 1'h1, 4'h2, 1'h1);
        settle();
        check({8'(rf_count - rf0), 4'(st_count - st0), char_offset}, 16'h0212);
        @(posedge ref_clk);
        {lat_en, lat_req} <= 2'h3;
        @(posedge ref_clk);
        lat_en <= 1'h0;
        @(posedge ref_clk);
        device_init_n <= 1'h0;
        #1;
        check({selftest_active, outputs_enabled, rx_channel_enabled}, 3'h7);
        check(4'(ebuf_wr_ptr - ebuf_rd_ptr), 4'h8);
        @(posedge ref_clk);
        device_init_n <= 1'h1;
        #1;
        check({selftest_active, outputs_enabled, rx_channel_enabled}, 3'h0);
        check({ebuf_wr_ptr, ebuf_rd_ptr, char_offset, status_ready}, 13'h1000);
        n = 0;
        while (status_ready !== 1'h1 && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(n < 16, 1'h1);
        check(rx_parallel_byte, 11'h000);
        test_done();
    end
endmodule
